/* hdl/sdd_map.vh */
`ifndef SDD_MAP_VH
`define SDD_MAP_VH

// register byte offsets on the AXI4-Lite port
`define SDD_CTRL_OFS     8'h00
`define SDD_STATUS_OFS   8'h04
`define SDD_MASK_OFS     8'h08
`define SDD_LASTBASE_OFS 8'h0c
`define SDD_LASTSIZE_OFS 8'h10
`define SDD_CSATTR_OFS   8'h14

// control bits
`define SDD_CTRL_FAULTEN 0
`define SDD_CTRL_RESET   1'b1

// status and mask bits
`define SDD_EV_FAULT     0
`define SDD_EV_LOAD      1
`define SDD_EV_BITS      2
`define SDD_STATUS_RESET 2'h0
`define SDD_MASK_RESET   2'h0

// code-segment attribute bits
`define SDD_CSATTR_DFLT  0
`define SDD_CSATTR_GRAN  1
`define SDD_CSATTR_LEGACY 2

// descriptor field positions, low word
`define SDD_LO_BASE_HI   31
`define SDD_LO_BASE_LO   16
`define SDD_LO_LIM_HI    15
`define SDD_LO_LIM_LO    0
// descriptor field positions, high word
`define SDD_HI_BASE3_HI  31
`define SDD_HI_BASE3_LO  24
`define SDD_HI_GRAN      23
`define SDD_HI_DFLT      22
`define SDD_HI_LIM_HI    19
`define SDD_HI_LIM_LO    16
`define SDD_HI_BASE2_HI  7
`define SDD_HI_BASE2_LO  0

// page size is 4K, legacy offsets must stay under 64K
`define SDD_PAGE_SHIFT   12
`define SDD_LEGACY_BITS  16

// slot that holds the current code segment
`define SDD_CS_SLOT      3'h1

// bus answers
`define SDD_RESP_OKAY    2'h0
`define SDD_RESP_SLVERR  2'h2

`endif

/* hdl/sdd_desc_ram.v */
`timescale 1ns/1ps
module sdd_desc_ram #(
  parameter AW = 3,
  parameter DW = 64
) (
  // clock
  input  wire          clk_sys,
  input  wire          clkEn,
  // write port
  input  wire          wrEn,
  input  wire [AW-1:0] wrAddr,
  input  wire [DW-1:0] wrData,
  // read port, data registered
  input  wire          rdEn,
  input  wire [AW-1:0] rdAddr,
  output reg  [DW-1:0] rdData
);

  reg [DW-1:0] mem [0:(1<<AW)-1];

  // read returns the old word when both ports hit one slot
  always @(posedge clk_sys) begin
    if (clkEn) begin
      if (wrEn) begin
        mem[wrAddr] <= wrData;
      end
      if (rdEn) begin
        rdData <= mem[rdAddr];
      end
    end
  end

endmodule

/* hdl/sdd_segment_decode.v */
// How it works
// - each descriptor yields a 32-bit base, a 20-bit limit, a default-size bit and a granularity bit.
// - base is low 31-16, high 7-0, high 31-24; limit is low 15-0 and high 19-16.
// - the code segment default bit picks 16-bit or 32-bit default operand and address size.
// - in real-address or virtual-8086 operation the code descriptor is ignored and the default bit is taken as 0.
// - granularity 1 makes the limit page granular, 0 makes it byte granular.
// - with page granularity the segment size is (limit + 1) times 4K.
// - in real-address or virtual-8086 operation an effective address of 64K or more raises a fault.
// - 32-bit addressing scales the index by 1, 2, 4 or 8 and wraps the address over 4G.
// - an operand-size or address-size prefix inverts the default size for its own instruction.
//
// Design decisions made here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "sdd_map.vh"
module sdd_segment_decode #(
  parameter SLOT_BITS = 3
) (
  // clock and reset
  input  wire                 clk_sys,
  input  wire                 rst_b,
  input  wire                 clkEn,
  // descriptor load from segment-loading logic
  input  wire                 descLoad,
  input  wire [SLOT_BITS-1:0] descSlot,
  input  wire [31:0]          descLow,
  input  wire [31:0]          descHigh,
  // operating mode
  input  wire                 realMode,
  input  wire                 v86Mode,
  // address request
  input  wire                 reqValid,
  input  wire [SLOT_BITS-1:0] reqSlot,
  input  wire                 reqOpPrefix,
  input  wire                 reqAddrPrefix,
  input  wire [31:0]          reqBase,
  input  wire [31:0]          reqIndex,
  input  wire [1:0]           reqScale,
  input  wire [31:0]          reqDisp,
  // decoded result
  output reg                  resValid,
  output reg  [31:0]          segBase,
  output reg  [19:0]          segLimit,
  output reg                  segDefault,
  output reg                  segGran,
  output reg  [32:0]          segSize,
  output reg                  operandWide,
  output reg                  addressWide,
  output reg  [31:0]          effAddr,
  output reg                  eaFault,
  // interrupt
  output reg                  irq,
  // axi4-lite slave
  input  wire [7:0]           s_axi_awaddr,
  input  wire                 s_axi_awvalid,
  output reg                  s_axi_awready,
  input  wire [31:0]          s_axi_wdata,
  input  wire [3:0]           s_axi_wstrb,
  input  wire                 s_axi_wvalid,
  output reg                  s_axi_wready,
  output reg  [1:0]           s_axi_bresp,
  output reg                  s_axi_bvalid,
  input  wire                 s_axi_bready,
  input  wire [7:0]           s_axi_araddr,
  input  wire                 s_axi_arvalid,
  output reg                  s_axi_arready,
  output reg  [31:0]          s_axi_rdata,
  output reg  [1:0]           s_axi_rresp,
  output reg                  s_axi_rvalid,
  input  wire                 s_axi_rready
);

  ////////////////////////////////////////////////////////////////////////////////
  // state

  reg                  faultEn;
  reg [`SDD_EV_BITS-1:0] status;
  reg [`SDD_EV_BITS-1:0] mask;
  reg                  csDefault;
  reg                  csGran;
  reg                  s1Valid;
  reg                  s1Legacy;
  reg                  s1Op;
  reg                  s1Addr;
  reg [31:0]           s1Base;
  reg [31:0]           s1Index;
  reg [1:0]            s1Scale;
  reg [31:0]           s1Disp;
  reg                  awHave;
  reg [7:0]            awAddr;
  reg                  wHave;
  reg [31:0]           wData;
  reg [3:0]            wStrb;
  wire [63:0]          rdDesc;

  ////////////////////////////////////////////////////////////////////////////////
  // descriptor store

  sdd_desc_ram #(
    .AW (SLOT_BITS),
    .DW (64)
  ) u_ram (
    .clk_sys (clk_sys),
    .clkEn   (clkEn),
    .wrEn    (descLoad),
    .wrAddr  (descSlot),
    .wrData  ({descHigh, descLow}),
    .rdEn    (reqValid),
    .rdAddr  (reqSlot),
    .rdData  (rdDesc)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // field extraction

  wire [31:0] dLow  = rdDesc[31:0];
  wire [31:0] dHigh = rdDesc[63:32];
  wire [31:0] fBase = {dHigh[`SDD_HI_BASE3_HI:`SDD_HI_BASE3_LO],
                       dHigh[`SDD_HI_BASE2_HI:`SDD_HI_BASE2_LO],
                       dLow[`SDD_LO_BASE_HI:`SDD_LO_BASE_LO]};
  wire [19:0] fLimit = {dHigh[`SDD_HI_LIM_HI:`SDD_HI_LIM_LO],
                        dLow[`SDD_LO_LIM_HI:`SDD_LO_LIM_LO]};
  wire        fGran = dHigh[`SDD_HI_GRAN];
  // cleared upper high word gives byte granularity and 16-bit default
  wire        fDflt = dHigh[`SDD_HI_DFLT];

  wire [20:0] limPlus = {1'b0, fLimit} + 21'h000001;
  wire [32:0] pageSize = {limPlus, {`SDD_PAGE_SHIFT{1'b0}}};
  wire [32:0] byteSize = {12'h000, limPlus};
  wire [32:0] next_size = fGran ? pageSize : byteSize;

  // legacy modes ignore the code descriptor and assume 16-bit
  wire next_dflt   = s1Legacy ? 1'b0 : csDefault;
  wire next_opWide = next_dflt ^ s1Op;
  wire next_adWide = next_dflt ^ s1Addr;

  ////////////////////////////////////////////////////////////////////////////////
  // effective address

  wire [31:0] scaled = s1Index << s1Scale;
  wire [31:0] ea32   = s1Base + scaled + s1Disp;
  wire [15:0] ea16   = s1Base[15:0] + s1Index[15:0] + s1Disp[15:0];
  wire [31:0] next_ea = next_adWide ? ea32 : {16'h0000, ea16};
  wire        next_fault = s1Valid & s1Legacy &
                           (next_ea[31:`SDD_LEGACY_BITS] != 16'h0000);

  ////////////////////////////////////////////////////////////////////////////////
  // request pipeline

  always @(posedge clk_sys) begin
    if (!rst_b) begin
      s1Valid   <= 1'b0;
      s1Legacy  <= 1'b0;
      s1Op      <= 1'b0;
      s1Addr    <= 1'b0;
      s1Base    <= 32'h0000_0000;
      s1Index   <= 32'h0000_0000;
      s1Scale   <= 2'h0;
      s1Disp    <= 32'h0000_0000;
      csDefault <= 1'b0;
      csGran    <= 1'b0;
    end else if (clkEn) begin
      s1Valid  <= reqValid;
      if (reqValid) begin
        s1Legacy <= realMode | v86Mode;
        s1Op     <= reqOpPrefix;
        s1Addr   <= reqAddrPrefix;
        s1Base   <= reqBase;
        s1Index  <= reqIndex;
        s1Scale  <= reqScale;
        s1Disp   <= reqDisp;
      end
      if (descLoad && descSlot == `SDD_CS_SLOT) begin
        csDefault <= descHigh[`SDD_HI_DFLT];
        csGran    <= descHigh[`SDD_HI_GRAN];
      end
    end
  end

  always @(posedge clk_sys) begin
    if (!rst_b) begin
      resValid    <= 1'b0;
      segBase     <= 32'h0000_0000;
      segLimit    <= 20'h00000;
      segDefault  <= 1'b0;
      segGran     <= 1'b0;
      segSize     <= 33'h0_0000_0000;
      operandWide <= 1'b0;
      addressWide <= 1'b0;
      effAddr     <= 32'h0000_0000;
      eaFault     <= 1'b0;
    end else if (clkEn) begin
      resValid <= s1Valid;
      eaFault  <= next_fault;
      if (s1Valid) begin
        segBase     <= fBase;
        segLimit    <= fLimit;
        segDefault  <= s1Legacy ? 1'b0 : fDflt;
        segGran     <= fGran;
        segSize     <= next_size;
        operandWide <= next_opWide;
        addressWide <= next_adWide;
        effAddr     <= next_ea;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // axi4-lite write channel

  wire       wrFire  = awHave & wHave & ~s_axi_bvalid;
  wire       wrCtrl  = wrFire & (awAddr == `SDD_CTRL_OFS);
  wire       wrStat  = wrFire & (awAddr == `SDD_STATUS_OFS);
  wire       wrMask  = wrFire & (awAddr == `SDD_MASK_OFS);
  wire       wrRo    = wrFire & ((awAddr == `SDD_LASTBASE_OFS) |
                                 (awAddr == `SDD_LASTSIZE_OFS) |
                                 (awAddr == `SDD_CSATTR_OFS));
  wire [`SDD_EV_BITS-1:0] evSet = {descLoad, next_fault & faultEn};
  wire [`SDD_EV_BITS-1:0] evClr = (wrStat & wStrb[0]) ? wData[`SDD_EV_BITS-1:0]
                                                      : {`SDD_EV_BITS{1'b0}};
  // set wins over a clear in the same cycle
  wire [`SDD_EV_BITS-1:0] next_status = (status & ~evClr) | evSet;

  always @(posedge clk_sys) begin
    if (!rst_b) begin
      awHave        <= 1'b0;
      awAddr        <= 8'h00;
      wHave         <= 1'b0;
      wData         <= 32'h0000_0000;
      wStrb         <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `SDD_RESP_OKAY;
      faultEn       <= `SDD_CTRL_RESET;
      status        <= `SDD_STATUS_RESET;
      mask          <= `SDD_MASK_RESET;
      irq           <= 1'b0;
    end else if (clkEn) begin
      s_axi_awready <= ~awHave & ~(s_axi_awvalid & s_axi_awready);
      s_axi_wready  <= ~wHave & ~(s_axi_wvalid & s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        awHave <= 1'b1;
        awAddr <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHave <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
      if (wrFire) begin
        awHave       <= 1'b0;
        wHave        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wrCtrl | wrStat | wrMask | wrRo) ? `SDD_RESP_OKAY
                                                          : `SDD_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wrCtrl && wStrb[0]) begin
        faultEn <= wData[`SDD_CTRL_FAULTEN];
      end
      if (wrMask && wStrb[0]) begin
        mask <= wData[`SDD_EV_BITS-1:0];
      end
      status <= next_status;
      irq    <= |(next_status & (wrMask && wStrb[0] ? wData[`SDD_EV_BITS-1:0] : mask));
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // axi4-lite read channel

  reg [31:0] rdMux;
  reg        rdHit;

  always @* begin
    rdHit = 1'b1;
    case ({s_axi_araddr[7:2], 2'b00})
      `SDD_CTRL_OFS:     rdMux = {31'h0000_0000, faultEn};
      `SDD_STATUS_OFS:   rdMux = {30'h0000_0000, status};
      `SDD_MASK_OFS:     rdMux = {30'h0000_0000, mask};
      `SDD_LASTBASE_OFS: rdMux = segBase;
      `SDD_LASTSIZE_OFS: rdMux = segSize[31:0];
      `SDD_CSATTR_OFS:   rdMux = {29'h0000_0000, s1Legacy, csGran, csDefault};
      default: begin
        rdMux = 32'h0000_0000;
        rdHit = 1'b0;
      end
    endcase
  end

  always @(posedge clk_sys) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `SDD_RESP_OKAY;
    end else if (clkEn) begin
      s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rdMux;
        s_axi_rresp  <= rdHit ? `SDD_RESP_OKAY : `SDD_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

/* test/sdd_chk.sv */
`timescale 1ns/1ps
module sdd_chk (
  // clock and reset
  input wire        clk_sys,
  input wire        rst_b,
  input wire        clkEn,
  // request
  input wire        reqValid,
  input wire        realMode,
  input wire        v86Mode,
  input wire        reqOpPrefix,
  // result
  input wire        resValid,
  input wire        segGran,
  input wire        segDefault,
  input wire [19:0] segLimit,
  input wire [32:0] segSize,
  input wire        operandWide,
  input wire        addressWide,
  input wire [31:0] effAddr,
  input wire        eaFault,
  // bus read
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire        s_axi_rvalid
);
  wire lg = realMode | v86Mode;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b || !clkEn);
  res_lat_a: assert property (reqValid |-> ##2 resValid)
    else $error("result late");
  size_page_a: assert property (resValid && segGran |->
    segSize == {1'b0, segLimit, 12'h0} + 33'h1000) else $error("page size wrong");
  size_byte_a: assert property (resValid && !segGran |->
    segSize == {13'h0, segLimit} + 33'h1) else $error("byte size wrong");
  legacy_dflt_a: assert property (reqValid && lg |-> ##2 !segDefault)
    else $error("default bit set in legacy mode");
  legacy_opsz_a: assert property (reqValid && lg |->
    ##2 operandWide == $past(reqOpPrefix, 2)) else $error("operand size wrong");
  ea_fault_a: assert property (resValid |->
    eaFault == ($past(lg, 2) && effAddr[31:16] != 16'h0)) else $error("fault wrong");
  narrow_ea_a: assert property (resValid && !addressWide |->
    effAddr[31:16] == 16'h0) else $error("narrow address too wide");
  read_rsp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind sdd_segment_decode sdd_chk sdd_chk_inst (.*);

/* test/sdd_cpu_model.sv */
`timescale 1ns/1ps
module sdd_cpu_model (
  // clock
  input wire          clk_sys,
  // descriptor load
  output logic        descLoad,
  output logic [2:0]  descSlot,
  output logic [31:0] descLow,
  output logic [31:0] descHigh,
  // request
  output logic        realMode,
  output logic        v86Mode,
  output logic        reqValid,
  output logic [2:0]  reqSlot,
  output logic        reqOpPrefix,
  output logic        reqAddrPrefix,
  output logic [31:0] reqBase,
  output logic [31:0] reqIndex,
  output logic [1:0]  reqScale,
  output logic [31:0] reqDisp
);
  initial begin
    {descLoad, descSlot, descLow, descHigh, realMode, v86Mode} = '0;
    {reqValid, reqSlot, reqOpPrefix, reqAddrPrefix, reqBase, reqIndex, reqScale, reqDisp} = '0;
  end
  // strobes stay up between back-to-back calls; idle drops them and inverts stale buses
  task automatic loadDesc(input logic [2:0] s, input logic [63:0] d);
    descLoad <= 1'b1;
    descSlot <= s;
    {descHigh, descLow} <= d;
    @(posedge clk_sys);
  endtask
  task automatic request(input logic [2:0] s, input logic rm, input logic vm, input logic op,
                         input logic ad, input logic [31:0] b, input logic [31:0] i,
                         input logic [1:0] sc, input logic [31:0] dp);
    {reqValid, reqSlot, realMode, v86Mode, reqOpPrefix, reqAddrPrefix} <= {1'b1, s, rm, vm, op, ad};
    {reqBase, reqIndex, reqScale, reqDisp} <= {b, i, sc, dp};
    @(posedge clk_sys);
  endtask
  task automatic idle();
    descLoad <= 1'b0;
    reqValid <= 1'b0;
    {descHigh, descLow} <= ~{descHigh, descLow};
    {reqBase, reqIndex, reqDisp} <= ~{reqBase, reqIndex, reqDisp};
    @(posedge clk_sys);
  endtask
endmodule

/* test/tb.sv */
`timescale 1ns/1ps
module tb;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic clkEn = 1'b1;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire descLoad, realMode, v86Mode, reqValid, reqOpPrefix, reqAddrPrefix;
  wire [2:0] descSlot, reqSlot;
  wire [31:0] descLow, descHigh, reqBase, reqIndex, reqDisp;
  wire [1:0] reqScale;
  wire resValid, segGran, segDefault, operandWide, addressWide, eaFault, irq;
  wire [31:0] segBase, effAddr;
  wire [19:0] segLimit;
  wire [32:0] segSize;
  wire [121:0] got = {segBase, segLimit, segGran, segDefault, segSize, operandWide, addressWide,
                      effAddr, eaFault};
  logic [121:0] expQ[$];
  logic [121:0] e;
  logic [63:0] dsc[8];
  logic [31:0] rd, r;
  logic [1:0] rs;
  logic lastLg, anyF;
  int seed = 67926;
  int fail_count = 0;
  int n_checks = 0;
  int cycles = 0;
  sdd_segment_decode sdd_segment_decode_inst (.*);
  sdd_cpu_model sdd_cpu_model_inst (.*);
  always #5 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [127:0] g, input logic [127:0] x);
    n_checks++;
    if (g !== x) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, g, x);
    end
  endtask
  task automatic axiWr(input logic [7:0] a, input logic [31:0] d);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic axiRd(input logic [7:0] a);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
    do begin
      @(posedge clk_sys);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    {rs, rd} = {s_axi_rresp, s_axi_rdata};
    s_axi_rready <= 1'b0;
    @(posedge clk_sys);
  endtask
  // expected result noted before the request goes out
  task automatic doReq(input logic [2:0] s, input logic rm, input logic vm, input logic op,
                       input logic ad, input logic [31:0] b, input logic [31:0] i,
                       input logic [1:0] sc, input logic [31:0] dp);
    logic [63:0] d;
    logic lg, dd, aw;
    logic [19:0] lim;
    logic [31:0] ea, t;
    logic [32:0] sz;
    d = dsc[s];
    lg = rm | vm;
    dd = lg ? 1'b0 : dsc[1][54];
    aw = dd ^ ad;
    lim = {d[51:48], d[15:0]};
    sz = {13'h0, lim} + 33'h1;
    if (d[55])
      sz = sz << 12;
    t = b + i + dp;
    ea = aw ? b + (i << sc) + dp : {16'h0, t[15:0]};
    expQ.push_back({d[63:56], d[39:32], d[31:16], lim, d[55], d[54] & !lg, sz, dd ^ op, aw, ea,
                    lg && ea[31:16] != 16'h0});
    lastLg = lg;
    anyF = anyF | (lg && ea[31:16] != 16'h0);
    sdd_cpu_model_inst.request(s, rm, vm, op, ad, b, i, sc, dp);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys) begin
    if (resValid === 1'b1) begin
      e = expQ.size() > 0 ? expQ.pop_front() : '1;
      chk(got, e);
    end
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      complete_run();
    end
  end
  initial begin
    repeat (10) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    axiWr(8'h0c, 32'hffff_ffff);
    chk(rs, 2'h0);
    axiWr(8'h18, 32'h0000_0000);
    chk(rs, 2'h2);
    foreach (dsc[k]) begin
      axiRd(8'h04 * k + 8'h0);
      chk({rs, rd}, k == 0 ? 34'h1 : k > 5 ? {2'h2, 32'h0} : 34'h0);
    end
    for (int p = 0; p < 2; p++) begin
      foreach (dsc[k])
        dsc[k] = {$random(seed), $random(seed)};
      dsc[1][54] = p[0];
      dsc[2][63:48] = 16'h0;
      dsc[3][55] = 1'b1;
      {dsc[3][51:48], dsc[3][15:0]} = 20'hfffff;
      dsc[4][55] = 1'b1;
      {dsc[4][51:48], dsc[4][15:0]} = 20'h0;
      dsc[5][55] = 1'b0;
      {dsc[5][51:48], dsc[5][15:0]} = 20'h0;
      foreach (dsc[k])
        sdd_cpu_model_inst.loadDesc(k, dsc[k]);
      sdd_cpu_model_inst.idle();
      // a load while the clock enable is low must leave the store alone
      clkEn <= 1'b0;
      sdd_cpu_model_inst.loadDesc(3'h5, ~dsc[5]);
      sdd_cpu_model_inst.idle();
      clkEn <= 1'b1;
      chk(irq, p);
      axiWr(8'h08, 32'h2 * (1 - p));
      chk(rs, 2'h0);
      @(posedge clk_sys);
      chk(irq, 1 - p);
      axiWr(8'h00, 1 - p);
      axiWr(8'h04, 32'h3);
      @(posedge clk_sys);
      chk(irq, 0);
      anyF = 1'b0;
      for (int k = 0; k < 24; k++) begin
        r = $random(seed);
        doReq(r[2:0], r[3] & r[9], r[4] & r[10], r[5], r[6], $random(seed), $random(seed),
              r[8:7], $random(seed));
      end
      sdd_cpu_model_inst.idle();
      repeat (3) @(posedge clk_sys);
      chk(expQ.size(), 0);
      axiRd(8'h04);
      chk({rs, rd}, {33'h0, anyF & ~p[0]});
      axiRd(8'h0c);
      chk({rs, rd}, {2'h0, e[121:90]});
      axiRd(8'h10);
      chk({rs, rd}, {2'h0, e[66:35]});
      axiRd(8'h14);
      chk({rs, rd}, {31'h0, lastLg, dsc[1][55], dsc[1][54]});
    end
    complete_run();
  end
endmodule
